// File: dv/dcq_core_model.sv
`timescale 1ns/1ps
// ========================================
// cpu core bus model
module dcq_core_model (
    input  wire logic   pclk,
    output logic        core_valid,
    output logic        core_read,
    output logic        core_paged,
    output logic [2:0]  core_page,
    output logic [15:0] core_cpu_addr,
    output logic        core_linear,
    output logic [16:0] core_linear_addr,
    output logic [7:0]  core_data
);
    initial begin
        core_valid = 1'b0;
        {core_read, core_paged, core_page, core_cpu_addr} = '0;
        {core_linear, core_linear_addr, core_data} = '0;
    end

    // idle lines carry junk so a stale value never passes for a live one
    always @(negedge pclk) begin
        if (!core_valid) begin
            {core_read, core_paged, core_page, core_cpu_addr} <=
                ~{core_read, core_paged, core_page, core_cpu_addr};
            {core_linear, core_linear_addr, core_data} <=
                ~{core_linear, core_linear_addr, core_data};
        end
    end

    task automatic cyc(input logic rd, input logic pg, input logic [2:0] pgn,
                       input logic [16:0] a, input logic [7:0] d);
        @(posedge pclk);
        core_valid <= 1'b1;
        core_read <= rd;
        core_paged <= pg;
        core_page <= pgn;
        core_linear <= !pg && a[16];
        core_linear_addr <= a;
        core_cpu_addr <= pg ? {2'b10, a[13:0]} : a[15:0];
        core_data <= d;
        @(posedge pclk);
        core_valid <= 1'b0;
    endtask
endmodule // dcq_core_model

// File: dv/tb_debug_comparator_qualifiers.sv
`timescale 1ns/1ps
`include "dcq_regs.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_debug_comparator_qualifiers;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        secure, end_trace_reset, match_a, match_b, match_c, clk_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        c_valid, c_read, c_paged, c_linear;
    logic [2:0]  c_page;
    logic [15:0] c_cpu;
    logic [16:0] c_lin;
    logic [7:0]  c_data;
    int          miscompares, tests_run;

    always #12.5 pclk = ~pclk;

    dcq_core_model u_core (.pclk(pclk), .core_valid(c_valid), .core_read(c_read),
        .core_paged(c_paged), .core_page(c_page), .core_cpu_addr(c_cpu),
        .core_linear(c_linear), .core_linear_addr(c_lin), .core_data(c_data));

    dcq_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .secure(secure),
        .end_trace_reset(end_trace_reset), .core_valid(c_valid), .core_read(c_read),
        .core_paged(c_paged), .core_page(c_page), .core_cpu_addr(c_cpu),
        .core_linear(c_linear), .core_linear_addr(c_lin), .core_data(c_data),
        .match_a(match_a), .match_b(match_b), .match_c(match_c));

    // ========================================
    // bus tasks
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        `CHK(rd, e);
    endtask

    task automatic q(input logic [7:0] x, input logic r, input logic p,
                     input logic [2:0] g, input logic [16:0] a, input logic e);
        apb(1'b1, `DCQ_IDX_CAX, {24'h0, x});
        apb(1'b1, `DCQ_IDX_CBX, {24'h0, x});
        apb(1'b1, `DCQ_IDX_CCX, {24'h0, x});
        u_core.cyc(r, p, g, a, 8'h00);
        #1;
        `CHK({match_c, match_b, match_a}, {3{e}});
    endtask

    task automatic etr();
        @(posedge pclk);
        end_trace_reset <= 1'b1;
        repeat (4) @(posedge pclk);
        end_trace_reset <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #(25 * 8000);
        miscompares++;
        test_done();
    end

    // ========================================
    // tests
    initial begin
        {pclk, presetn, psel, penable, pwrite, secure, end_trace_reset} = '0;
        clk_en = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        miscompares = 0;
        tests_run = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rdchk(`DCQ_IDX_CBX, 32'h0);
        rdchk(`DCQ_IDX_CCX, 32'h0);
        apb(1'b1, `DCQ_IDX_CBX, 32'hffff_ffff);
        rdchk(`DCQ_IDX_CBX, 32'he1);
        apb(1'b1, `DCQ_IDX_CCX, 32'hffff_ffff);
        rdchk(`DCQ_IDX_CCX, 32'he1);
        apb(1'b0, 8'h0f, 32'h0);
        `CHK(err, 1'b1);
        `CHK(rd, 32'h0);
        $display("test registers done");
        apb(1'b1, `DCQ_IDX_CTRL, 32'h80);
        apb(1'b1, `DCQ_IDX_CMPA, 32'h34);
        apb(1'b1, `DCQ_IDX_CMPB, 32'h34);
        apb(1'b1, `DCQ_IDX_CMPC, 32'h34);
        q(8'h00, 1, 0, 3'h0, 17'h00034, 1);
        q(8'h00, 0, 0, 3'h0, 17'h00034, 1);
        q(8'h40, 0, 0, 3'h0, 17'h00034, 1);
        q(8'hc0, 1, 0, 3'h0, 17'h00034, 1);
        q(8'hc0, 0, 0, 3'h0, 17'h00034, 0);
        q(8'h80, 1, 0, 3'h0, 17'h00034, 0);
        q(8'h20, 0, 1, 3'h1, 17'h00034, 1);
        q(8'h00, 0, 1, 3'h1, 17'h00034, 0);
        q(8'h20, 0, 0, 3'h0, 17'h00034, 0);
        q(8'h01, 0, 0, 3'h0, 17'h10034, 1);
        q(8'h01, 0, 0, 3'h0, 17'h00034, 0);
        q(8'h21, 0, 1, 3'h4, 17'h00034, 1);
        q(8'h00, 0, 0, 3'h0, 17'h00035, 0);
        $display("test qualifiers done");
        apb(1'b1, `DCQ_IDX_CTRL, 32'h82);
        apb(1'b1, `DCQ_IDX_CAX, 32'hc0);
        apb(1'b1, `DCQ_IDX_CBX, 32'h21);
        apb(1'b1, `DCQ_IDX_CMPB, 32'h5a);
        u_core.cyc(1'b0, 1'b0, 3'h0, 17'h00034, 8'h5a);
        #1;
        `CHK({match_b, match_a}, 2'b00);
        u_core.cyc(1'b1, 1'b0, 3'h0, 17'h00034, 8'h5a);
        #1;
        `CHK({match_b, match_a}, 2'b11);
        @(posedge pclk);
        clk_en <= 1'b0;
        u_core.cyc(1'b1, 1'b0, 3'h0, 17'h00034, 8'h5a);
        #1;
        `CHK({match_b, match_a}, 2'b00);
        @(posedge pclk);
        clk_en <= 1'b1;
        $display("test full mode done");
        apb(1'b1, `DCQ_IDX_CTRL, 32'h81);
        apb(1'b1, `DCQ_IDX_CBX, 32'he1);
        etr();
        rdchk(`DCQ_IDX_CBX, 32'he1);
        apb(1'b1, `DCQ_IDX_CTRL, 32'h80);
        etr();
        rdchk(`DCQ_IDX_CBX, 32'h00);
        $display("test end trace done");
        secure <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(`DCQ_IDX_CTRL, 32'h00);
        apb(1'b1, `DCQ_IDX_CTRL, 32'h80);
        rdchk(`DCQ_IDX_CTRL, 32'h00);
        secure <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, `DCQ_IDX_CTRL, 32'h80);
        rdchk(`DCQ_IDX_CTRL, 32'h80);
        $display("test secure done");
        test_done();
    end
endmodule // tb_debug_comparator_qualifiers

// File: shared/dcq_pkg.sv
package dcq_pkg;
    typedef struct packed {
        logic        valid;
        logic        read;
        logic        paged;
        logic [2:0]  page;
        logic [16:0] addr;
        logic [7:0]  data;
    } dcq_bus_type;

    typedef struct packed {
        logic        dir_en;
        logic        dir_val;
        logic        page_sel;
        logic        a16;
    } dcq_qual_type;
endpackage

// File: shared/dcq_regs.svh
`ifndef DCQ_REGS_SVH
`define DCQ_REGS_SVH
// register indices; the byte address is four times the index
`define DCQ_IDX_CAX      8'h08
`define DCQ_IDX_CBX      8'h09
`define DCQ_IDX_CCX      8'h0a
`define DCQ_IDX_CTRL     8'h0c
`define DCQ_IDX_CMPA     8'h10
`define DCQ_IDX_CMPB     8'h11
`define DCQ_IDX_CMPC     8'h12
`define DCQ_IDX_STAT     8'h13
`define DCQ_BIT_DIR_EN   7
`define DCQ_BIT_DIR_VAL  6
`define DCQ_BIT_PAGE     5
`define DCQ_BIT_A16      0
`define DCQ_EXT_MASK     8'he1
`define DCQ_EXT_RST      8'h00
`define DCQ_CTRL_RST     8'h00
`define DCQ_BIT_DEBUG_EN 7
`define DCQ_BIT_FULL     1
`define DCQ_BIT_CAPEND   0
`endif

// File: src/dcq_qualifier.sv
`timescale 1ns/1ps
`include "dcq_regs.svh"
module dcq_qualifier (
    input  wire logic                 cmp_hit,
    input  wire dcq_pkg::dcq_qual_type q,
    input  wire logic                 use_page,
    input  wire dcq_pkg::dcq_bus_type  bus,
    output logic                      match
);
    logic dir_ok;
    logic page_ok;
    logic a16_ok;

    always_comb begin
        dir_ok  = !q.dir_en || (bus.read == q.dir_val);
        page_ok = !use_page || (bus.paged == q.page_sel);
        a16_ok  = !use_page || (bus.addr[16] == q.a16);
        match   = bus.valid && cmp_hit && dir_ok && page_ok && a16_ok;
    end
endmodule // dcq_qualifier

// File: src/dcq_top.sv
`timescale 1ns/1ps
`include "dcq_regs.svh"
// Functional notes
// - comparator b uses direction only when its own (or, in full mode, a's) direction enable is set
// - comparator b direction value: 0 matches writes, 1 matches reads
// - full modes: b takes direction enable and value from comparator a
// - b page select requires paged flag equal to the bit
// - b bit-0 field gives expected core address bit 16
// - full modes: b page select and bit-16 bits have no effect
// - comparator c uses direction only when its direction enable is set
// - comparator c direction value: 0 matches writes, 1 matches reads
// - c page select requires paged flag equal to the bit
// - c bit-0 field gives expected core address bit 16
// - core address: page:addr[13:0] when paged, else cpu or linear address
// - end-trace reset with debug enabled and capture keeps extension bits
// - comparator a direction value: 0 writes, 1 reads, ignored if disabled
// - debug enable forced low and unsettable while device secured
module dcq_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        secure,
    input  wire logic        end_trace_reset,
    input  wire logic        core_valid,
    input  wire logic        core_read,
    input  wire logic        core_paged,
    input  wire logic [2:0]  core_page,
    input  wire logic [15:0] core_cpu_addr,
    input  wire logic        core_linear,
    input  wire logic [16:0] core_linear_addr,
    input  wire logic [7:0]  core_data,
    output logic             match_a,
    output logic             match_b,
    output logic             match_c
);
    // =========================================================
    // registers
    logic [7:0]  cax_r;
    logic [7:0]  cbx_r;
    logic [7:0]  ccx_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  cmpa_r;
    logic [7:0]  cmpb_r;
    logic [7:0]  cmpc_r;
    logic [7:0]  cax_nxt;
    logic [7:0]  cbx_nxt;
    logic [7:0]  ccx_nxt;
    logic [7:0]  ctrl_nxt;
    logic [7:0]  cmpa_nxt;
    logic [7:0]  cmpb_nxt;
    logic [7:0]  cmpc_nxt;
    logic [7:0]  reg_idx;
    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;
    logic        ma_nxt;
    logic        mb_nxt;
    logic        mc_nxt;
    logic        keep;
    logic        wr_en;
    logic        sec_s1_r;
    logic        sec_r;
    logic        etr_s1_r;
    logic        etr_r;

    function automatic logic known(input logic [7:0] a);
        logic [7:0] i;
        i = {2'b00, a[7:2]};
        known = a[1:0] == 2'b00 && (i == `DCQ_IDX_CAX || i == `DCQ_IDX_CBX
              || i == `DCQ_IDX_CCX || i == `DCQ_IDX_CTRL
              || i == `DCQ_IDX_CMPA || i == `DCQ_IDX_CMPB
              || i == `DCQ_IDX_CMPC || i == `DCQ_IDX_STAT);
    endfunction

    // two-flop sync of secure and end-trace-reset pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_s1_r <= 1'b1;
            sec_r    <= 1'b1;
            etr_s1_r <= 1'b0;
            etr_r    <= 1'b0;
        end else if (clk_en) begin
            sec_s1_r <= secure;
            sec_r    <= sec_s1_r;
            etr_s1_r <= end_trace_reset;
            etr_r    <= etr_s1_r;
        end
    end

    // =========================================================
    // apb slave, zero wait states
    always_comb begin
        cax_nxt = cax_r;
        cbx_nxt = cbx_r;
        ccx_nxt = ccx_r;
        ctrl_nxt = ctrl_r;
        cmpa_nxt = cmpa_r;
        cmpb_nxt = cmpb_r;
        cmpc_nxt = cmpc_r;
        prdata_nxt = 32'h0000_0000;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        // soft reset: extension bits survive only an end-trace reset with debug enabled and capture on
        keep = ctrl_r[`DCQ_BIT_DEBUG_EN] && ctrl_r[`DCQ_BIT_CAPEND];
        reg_idx = {2'b00, paddr[7:2]};
        // write lands at the access edge, where the master sees pready high
        wr_en = psel && penable && pready && pwrite && known(paddr);
        if (psel && !penable) begin
            pready_nxt = 1'b1;
            pslverr_nxt = !known(paddr);
            if (!pwrite) begin
                unique case (reg_idx)
                    `DCQ_IDX_CAX:  prdata_nxt = {24'h0, cax_r};
                    `DCQ_IDX_CBX:  prdata_nxt = {24'h0, cbx_r};
                    `DCQ_IDX_CCX:  prdata_nxt = {24'h0, ccx_r};
                    `DCQ_IDX_CTRL: prdata_nxt = {24'h0, ctrl_r};
                    `DCQ_IDX_CMPA: prdata_nxt = {24'h0, cmpa_r};
                    `DCQ_IDX_CMPB: prdata_nxt = {24'h0, cmpb_r};
                    `DCQ_IDX_CMPC: prdata_nxt = {24'h0, cmpc_r};
                    `DCQ_IDX_STAT: prdata_nxt = {29'h0, match_c, match_b, match_a};
                    default:       prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
        if (wr_en) begin
            unique case (reg_idx)
                `DCQ_IDX_CAX:  cax_nxt = pwdata[7:0] & `DCQ_EXT_MASK;
                `DCQ_IDX_CBX:  cbx_nxt = pwdata[7:0] & `DCQ_EXT_MASK;
                `DCQ_IDX_CCX:  ccx_nxt = pwdata[7:0] & `DCQ_EXT_MASK;
                `DCQ_IDX_CTRL: ctrl_nxt = pwdata[7:0];
                `DCQ_IDX_CMPA: cmpa_nxt = pwdata[7:0];
                `DCQ_IDX_CMPB: cmpb_nxt = pwdata[7:0];
                `DCQ_IDX_CMPC: cmpc_nxt = pwdata[7:0];
                default: ;
            endcase
        end
        if (etr_r && !keep) begin
            cax_nxt = `DCQ_EXT_RST;
            cbx_nxt = `DCQ_EXT_RST;
            ccx_nxt = `DCQ_EXT_RST;
        end
        if (sec_r) begin
            ctrl_nxt[`DCQ_BIT_DEBUG_EN] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cax_r   <= `DCQ_EXT_RST;
            cbx_r   <= `DCQ_EXT_RST;
            ccx_r   <= `DCQ_EXT_RST;
            ctrl_r  <= `DCQ_CTRL_RST;
            cmpa_r  <= 8'h00;
            cmpb_r  <= 8'h00;
            cmpc_r  <= 8'h00;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            cax_r   <= cax_nxt;
            cbx_r   <= cbx_nxt;
            ccx_r   <= ccx_nxt;
            ctrl_r  <= ctrl_nxt;
            cmpa_r  <= cmpa_nxt;
            cmpb_r  <= cmpb_nxt;
            cmpc_r  <= cmpc_nxt;
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // =========================================================
    // core address and comparators
    dcq_pkg::dcq_bus_type  bus;
    dcq_pkg::dcq_qual_type qa;
    dcq_pkg::dcq_qual_type qb;
    dcq_pkg::dcq_qual_type qc;
    logic                  full;
    logic                  hit_a;
    logic                  hit_b;
    logic                  hit_c;

    always_comb begin
        full = ctrl_r[`DCQ_BIT_FULL];
        bus.valid = core_valid && ctrl_r[`DCQ_BIT_DEBUG_EN];
        bus.read  = core_read;
        bus.paged = core_paged;
        bus.page  = core_page;
        bus.data  = core_data;
        if (core_paged)
            bus.addr = {core_page, core_cpu_addr[13:0]};
        else if (core_linear)
            bus.addr = core_linear_addr;
        else
            bus.addr = {1'b0, core_cpu_addr};
        // only low byte of address compared; a is the direction master
        qa = {cax_r[`DCQ_BIT_DIR_EN], cax_r[`DCQ_BIT_DIR_VAL],
              cax_r[`DCQ_BIT_PAGE], cax_r[`DCQ_BIT_A16]};
        qc = {ccx_r[`DCQ_BIT_DIR_EN], ccx_r[`DCQ_BIT_DIR_VAL],
              ccx_r[`DCQ_BIT_PAGE], ccx_r[`DCQ_BIT_A16]};
        qb = {cbx_r[`DCQ_BIT_DIR_EN], cbx_r[`DCQ_BIT_DIR_VAL],
              cbx_r[`DCQ_BIT_PAGE], cbx_r[`DCQ_BIT_A16]};
        if (full) begin
            qb.dir_en  = qa.dir_en;
            qb.dir_val = qa.dir_val;
        end
        hit_a = bus.addr[7:0] == cmpa_r;
        hit_b = full ? (bus.data == cmpb_r) : (bus.addr[7:0] == cmpb_r);
        hit_c = bus.addr[7:0] == cmpc_r;
    end

    dcq_qualifier u_qa (.cmp_hit(hit_a), .q(qa), .use_page(1'b1), .bus(bus), .match(ma_nxt));
    dcq_qualifier u_qb (.cmp_hit(hit_b), .q(qb), .use_page(!full), .bus(bus),
                        .match(mb_nxt));
    dcq_qualifier u_qc (.cmp_hit(hit_c), .q(qc), .use_page(1'b1), .bus(bus), .match(mc_nxt));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_a <= 1'b0;
            match_b <= 1'b0;
            match_c <= 1'b0;
        end else if (clk_en) begin
            match_a <= ma_nxt;
            match_b <= mb_nxt;
            match_c <= mc_nxt;
        end
    end

    // =========================================================
    // checks
    a_enable_secure: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && sec_r |=> !ctrl_r[`DCQ_BIT_DEBUG_EN])
        else $error("debug enable set while secure");
    a_c_dir_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && qc.dir_en && !qc.dir_val && core_read |=> !match_c)
        else $error("c matched read");
    a_c_dir_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && qc.dir_en && qc.dir_val && !core_read |=> !match_c)
        else $error("c matched write");
    a_c_dir_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && !qc.dir_en && bus.valid && bus.addr[7:0] == cmpc_r
        && core_paged == qc.page_sel && bus.addr[16] == qc.a16 |=> match_c)
        else $error("c missed with direction off");
    a_c_page: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && core_paged != qc.page_sel |=> !match_c)
        else $error("c page");
    a_c_a16: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && bus.addr[16] != qc.a16 |=> !match_c)
        else $error("c bit16");
    a_c_hit: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && bus.addr[7:0] != cmpc_r |=> !match_c)
        else $error("c matched other address");
    a_a_dir: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && qa.dir_en && core_read != qa.dir_val |=> !match_a)
        else $error("a direction");
    a_b_dir_full: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && full && qa.dir_en && core_read != qa.dir_val |=> !match_b)
        else $error("b full dir");
    a_b_full_data: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && full && bus.valid && core_data == cmpb_r
        && (!qa.dir_en || core_read == qa.dir_val) |=> match_b)
        else $error("b full mode missed data");
    a_b_page: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && !full && core_paged != cbx_r[`DCQ_BIT_PAGE] |=> !match_b)
        else $error("b page");
    a_b_a16: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && !full && bus.addr[16] != cbx_r[`DCQ_BIT_A16] |=> !match_b)
        else $error("b bit16");
    a_b_dir: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && !full && cbx_r[`DCQ_BIT_DIR_EN]
        && core_read != cbx_r[`DCQ_BIT_DIR_VAL] |=> !match_b)
        else $error("b dir");
    a_b_dir_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && !full && !cbx_r[`DCQ_BIT_DIR_EN] && bus.valid
        && bus.addr[7:0] == cmpb_r && core_paged == cbx_r[`DCQ_BIT_PAGE]
        && bus.addr[16] == cbx_r[`DCQ_BIT_A16] |=> match_b)
        else $error("b missed with direction off");
    a_match_valid: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && !bus.valid |=> !match_a && !match_b && !match_c)
        else $error("match without live bus cycle");
    a_paged_addr: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_paged |-> bus.addr[16:14] == core_page)
        else $error("paged address");
    a_ext_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && etr_r && keep && !wr_en |=> $stable(cbx_r))
        else $error("ext lost");
    a_ext_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && etr_r && !keep |=> cbx_r == `DCQ_EXT_RST && ccx_r == `DCQ_EXT_RST)
        else $error("ext not cleared");
    a_pready_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && pready |=> !pready)
        else $error("pready longer than one cycle");
endmodule // dcq_top
